// ==== logic/radio_receive_control.sv ====
// Receive control: state commands, frame events, link quality, protection.
`timescale 1ns/1ps

module radio_receive_control
	import radio_rx_pkg::*;
#(
	parameter int FB_ADDR_WIDTH = 7,
	parameter int LQI_SHIFT     = 3
) (
	input  wire logic                     clock,
	input  wire logic                     rst,
	input  wire logic                     clk_en,
	input  wire logic [5:0]               reg_addr,
	input  wire logic [7:0]               reg_wdata,
	input  wire logic                     reg_wr,
	input  wire logic                     reg_rd,
	output logic      [7:0]               reg_rdata,
	output logic                          irq,
	input  wire demod_in_t                demod,
	input  wire logic                     sel_n,
	input  wire logic                     frame_read_mode,
	output fb_write_t                     fb_write,
	output state_control_register_t                    state_control_register
);

	////////////////////////////////////////////////////////////////////////
	// State.

	state_control_register_t                state_reg;
	state_control_register_t                state_next;
	logic [7:0]                sync_ctrl_reg;
	logic [7:0]                ctrl_two_reg;
	logic [7:0]                ed_reg;
	logic                      fcs_ok_reg;
	logic                      pending_reg;
	logic [7:0]                lqi_reg;
	logic [7:0]                irq_status_reg;
	logic [7:0]                irq_status_next;
	logic [7:0]                irq_mask_reg;
	logic                      protect_reg;
	logic                      sel_n_prev_reg;
	logic [FB_ADDR_WIDTH-1:0]  wr_ptr_reg;
	logic [15:0]               corr_sum_reg;
	logic [7:0]                octet_cnt_reg;
	logic [7:0]                rdata_reg;
	logic                      irq_reg;
	fb_write_t                 fb_reg;
	fb_write_t                 fb_next;

	////////////////////////////////////////////////////////////////////////
	// Decoding.

	wire wr_state   = reg_wr && (reg_addr == STATE_CONTROL_ADDR);
	wire wr_sync    = reg_wr && (reg_addr == SYNC_CONTROL_ADDR);
	wire wr_ctrl2   = reg_wr && (reg_addr == CONTROL_TWO_ADDR);
	wire wr_mask    = reg_wr && (reg_addr == IRQ_MASK_ADDR);
	wire rd_status  = reg_rd && (reg_addr == IRQ_STATUS_ADDR);
	wire [4:0] cmd  = reg_wdata[4:0];

	wire sync_disable = sync_ctrl_reg[SYNC_DISABLE_BIT];
	wire [3:0] sync_threshold = sync_ctrl_reg[3:0];
	wire safe_mode = ctrl_two_reg[SAFE_MODE_BIT];

	wire listening = (state_reg == ST_RX_LISTEN) ||
		(state_reg == ST_AACK_LISTEN);
	wire receiving = (state_reg == ST_RX_BUSY) ||
		(state_reg == ST_AACK_BUSY);
	wire extended  = (state_reg == ST_AACK_BUSY);

	// A level of N steps above the floor clears threshold N; zero passes all.
	wire strong_enough = ({1'b0, sync_threshold} <= demod.signal_level);
	wire frame_start = listening && demod.sync_found && strong_enough &&
		!sync_disable && !protect_reg;
	wire frame_end = receiving && demod.frame_end;

	// Extended mode drops frames that are not addressed to this node.
	wire frame_accepted = frame_end && (!extended || demod.addr_match);

	wire long_enough = (octet_cnt_reg >= LQI_MIN_OCTETS);
	wire [15:0] corr_scaled = corr_sum_reg >> LQI_SHIFT;
	wire [7:0] lqi_value = !long_enough ? 8'h00 :
		(corr_scaled > 16'h00FF) ? 8'hFF : corr_scaled[7:0];

	wire sel_rise = sel_n && !sel_n_prev_reg;
	wire protect_release = protect_reg && frame_read_mode && sel_rise;

	wire [7:0] state_code = {5'h00, state_reg};
	wire [7:0] strength_code = {fcs_ok_reg, pending_reg, 1'b0,
		demod.signal_level};

	////////////////////////////////////////////////////////////////////////
	// Read selection.

	wire rd_state_sel    = reg_rd && (reg_addr == STATE_STATUS_ADDR);
	wire rd_strength_sel = reg_rd && (reg_addr == SIGNAL_STRENGTH_ADDR);
	wire rd_energy_sel   = reg_rd && (reg_addr == ENERGY_LEVEL_ADDR);
	wire rd_ctrl2_sel    = reg_rd && (reg_addr == CONTROL_TWO_ADDR);
	wire rd_mask_sel     = reg_rd && (reg_addr == IRQ_MASK_ADDR);
	wire rd_sync_sel     = reg_rd && (reg_addr == SYNC_CONTROL_ADDR);
	wire rd_lqi_sel      = reg_rd && (reg_addr == LQI_ADDR);

	// Unmapped addresses and idle cycles read as zero.
	wire [7:0] rdata_next =
		rd_state_sel    ? state_code :
		rd_strength_sel ? strength_code :
		rd_energy_sel   ? ed_reg :
		rd_ctrl2_sel    ? ctrl_two_reg :
		rd_mask_sel     ? irq_mask_reg :
		rd_status       ? irq_status_reg :
		rd_sync_sel     ? sync_ctrl_reg :
		rd_lqi_sel      ? lqi_reg : 8'h00;

	////////////////////////////////////////////////////////////////////////
	// State machine.

	always_comb begin
		state_next = state_reg;
		case (state_reg)
		ST_IDLE, ST_LOCKED: begin
			if (wr_state && cmd == CMD_RX)
				state_next = ST_RX_LISTEN;
			else if (wr_state && cmd == CMD_AACK_RX)
				state_next = ST_AACK_LISTEN;
			else if (wr_state && cmd == CMD_ARET_TX)
				state_next = ST_ARET_TX;
			else if (wr_state && cmd == CMD_IDLE)
				state_next = ST_IDLE;
			else if (wr_state && cmd == CMD_LOCK)
				state_next = ST_LOCKED;
		end
		ST_ARET_TX: begin
			if (wr_state && cmd == CMD_AACK_RX)
				state_next = ST_AACK_LISTEN;
			else if (wr_state && cmd == CMD_IDLE)
				state_next = ST_IDLE;
			else if (wr_state && cmd == CMD_LOCK)
				state_next = ST_LOCKED;
		end
		ST_RX_LISTEN, ST_AACK_LISTEN: begin
			if (frame_start)
				state_next = (state_reg == ST_RX_LISTEN) ?
					ST_RX_BUSY : ST_AACK_BUSY;
			// A protected frame pins the receiver in its listening state.
			else if (wr_state && !protect_reg && cmd == CMD_IDLE)
				state_next = ST_IDLE;
			else if (wr_state && !protect_reg && cmd == CMD_LOCK)
				state_next = ST_LOCKED;
		end
		ST_RX_BUSY:
			if (frame_end)
				state_next = ST_RX_LISTEN;
		ST_AACK_BUSY:
			if (frame_end)
				state_next = ST_AACK_LISTEN;
		default:
			state_next = ST_IDLE;
		endcase
	end

	////////////////////////////////////////////////////////////////////////
	// Frame buffer writes and event flags.

	always_comb begin
		fb_next = '0;
		if (receiving && demod.octet_valid && !frame_end) begin
			fb_next.we   = 1'b1;
			fb_next.addr = wr_ptr_reg;
			fb_next.data = demod.octet;
		end else if (frame_accepted) begin
			fb_next.we   = 1'b1;
			fb_next.addr = wr_ptr_reg;
			fb_next.data = lqi_value;
		end
	end

	// A new event in the same cycle as the clearing read survives.
	always_comb begin
		irq_status_next = rd_status ? 8'h00 : irq_status_reg;
		if (frame_start)
			irq_status_next[IRQ_FRAME_START_BIT] = 1'b1;
		if (frame_accepted)
			irq_status_next[IRQ_FRAME_DONE_BIT] = 1'b1;
	end

	////////////////////////////////////////////////////////////////////////
	// Registers.

	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			state_reg <= ST_IDLE;
		end else if (clk_en) begin
			state_reg <= state_next;
		end
	end

	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			rdata_reg <= 8'h00;
		end else if (clk_en) begin
			rdata_reg <= rdata_next;
		end
	end

	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			irq_status_reg <= IRQ_STATUS_RESET;
		end else if (clk_en) begin
			irq_status_reg <= irq_status_next;
		end
	end

	// The level follows the next status, so it rises with the event bit.
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			irq_reg <= 1'b0;
		end else if (clk_en) begin
			irq_reg <= |(irq_status_next & irq_mask_reg);
		end
	end

	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			fb_reg <= '0;
		end else if (clk_en) begin
			fb_reg <= fb_next;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Host registers.

	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			sync_ctrl_reg <= SYNC_CONTROL_RESET;
		end else if (clk_en && wr_sync) begin
			sync_ctrl_reg <= reg_wdata & SYNC_CONTROL_RW_MASK;
		end
	end

	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			ctrl_two_reg <= CONTROL_TWO_RESET;
		end else if (clk_en && wr_ctrl2) begin
			ctrl_two_reg <= reg_wdata;
		end
	end

	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			irq_mask_reg <= IRQ_MASK_RESET;
		end else if (clk_en && wr_mask) begin
			irq_mask_reg <= reg_wdata;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Frame status.

	// Status captured once per accepted frame.
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			ed_reg      <= ENERGY_RESET;
			fcs_ok_reg  <= 1'b0;
			pending_reg <= 1'b0;
			lqi_reg     <= LQI_RESET;
		end else if (clk_en && frame_accepted) begin
			ed_reg      <= demod.ed_level;
			fcs_ok_reg  <= demod.fcs_ok;
			pending_reg <= extended && demod.pending;
			lqi_reg     <= lqi_value;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Tallies.

	// Both tallies saturate, so a long frame cannot wrap to a low quality.
	wire corr_add  = receiving && demod.symbol_valid &&
		(corr_sum_reg < 16'hFF00);
	wire octet_add = receiving && demod.octet_valid &&
		(octet_cnt_reg != 8'hFF);

	// Correlation and length tallies restart at every frame start.
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			corr_sum_reg <= 16'h0000;
		end else if (clk_en && frame_start) begin
			corr_sum_reg <= 16'h0000;
		end else if (clk_en && corr_add) begin
			corr_sum_reg <= corr_sum_reg +
				{8'h00, demod.correlation};
		end
	end

	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			octet_cnt_reg <= 8'h00;
		end else if (clk_en && frame_start) begin
			octet_cnt_reg <= 8'h00;
		end else if (clk_en && octet_add) begin
			octet_cnt_reg <= octet_cnt_reg + 8'h01;
		end
	end

	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			wr_ptr_reg <= '0;
		end else if (clk_en && frame_start) begin
			wr_ptr_reg <= '0;
		end else if (clk_en && receiving && fb_next.we) begin
			wr_ptr_reg <= wr_ptr_reg + FB_ADDR_WIDTH'(1);
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Protection.

	// Protection is held only for good frames, until the host deselects in frame read mode.
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			protect_reg    <= 1'b0;
			sel_n_prev_reg <= 1'b1;
		end else if (clk_en) begin
			sel_n_prev_reg <= sel_n;
			if (frame_accepted && safe_mode && demod.fcs_ok)
				protect_reg <= 1'b1;
			else if (protect_release)
				protect_reg <= 1'b0;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Outputs.

	assign reg_rdata = rdata_reg;
	assign irq       = irq_reg;
	assign fb_write  = fb_reg;
	assign state_control_register = state_reg;

endmodule // radio_receive_control

// ==== shared/radio_rx_pkg.sv ====
// Constants and carrier types shared by the receive control block.
package radio_rx_pkg;

	// Register offsets on the 6-bit register port.
	localparam logic [5:0] STATE_STATUS_ADDR   = 6'h01;
	localparam logic [5:0] STATE_CONTROL_ADDR  = 6'h02;
	localparam logic [5:0] SIGNAL_STRENGTH_ADDR = 6'h06;
	localparam logic [5:0] ENERGY_LEVEL_ADDR   = 6'h07;
	localparam logic [5:0] CONTROL_TWO_ADDR    = 6'h0C;
	localparam logic [5:0] IRQ_MASK_ADDR       = 6'h0E;
	localparam logic [5:0] IRQ_STATUS_ADDR     = 6'h0F;
	localparam logic [5:0] SYNC_CONTROL_ADDR   = 6'h15;
	localparam logic [5:0] LQI_ADDR            = 6'h16;

	// Field positions.
	localparam int SYNC_DISABLE_BIT   = 7;
	localparam int SAFE_MODE_BIT      = 7;
	localparam int FCS_OK_BIT         = 7;
	localparam int PENDING_BIT        = 6;
	localparam int IRQ_FRAME_START_BIT = 2;
	localparam int IRQ_FRAME_DONE_BIT  = 3;

	// Reset values.
	localparam logic [7:0] SYNC_CONTROL_RESET = 8'h00;
	localparam logic [7:0] CONTROL_TWO_RESET  = 8'h00;
	localparam logic [7:0] IRQ_MASK_RESET     = 8'h00;
	localparam logic [7:0] IRQ_STATUS_RESET   = 8'h00;
	localparam logic [7:0] ENERGY_RESET       = 8'h00;
	localparam logic [7:0] LQI_RESET          = 8'h00;

	// Writable bits of the sync control register; reserved bits 6 to 4 read as zero.
	localparam logic [7:0] SYNC_CONTROL_RW_MASK = 8'h8F;

	// Frames shorter than this many octets give no meaningful quality.
	localparam logic [7:0] LQI_MIN_OCTETS = 8'h02;

	// Commands written to the state command field.
	localparam logic [4:0] CMD_IDLE     = 5'h01;
	localparam logic [4:0] CMD_LOCK     = 5'h02;
	localparam logic [4:0] CMD_RX       = 5'h03;
	localparam logic [4:0] CMD_AACK_RX  = 5'h04;
	localparam logic [4:0] CMD_ARET_TX  = 5'h05;

	typedef enum logic [2:0] {
		ST_IDLE,
		ST_LOCKED,
		ST_RX_LISTEN,
		ST_RX_BUSY,
		ST_AACK_LISTEN,
		ST_AACK_BUSY,
		ST_ARET_TX
	} state_control_register_t;

	// Strobes and values from the demodulator.
	typedef struct packed {
		logic       sync_found;
		logic [4:0] signal_level;
		logic       symbol_valid;
		logic [7:0] correlation;
		logic       octet_valid;
		logic [7:0] octet;
		logic       frame_end;
		logic       fcs_ok;
		logic [7:0] ed_level;
		logic       addr_match;
		logic       pending;
	} demod_in_t;

	// One write into the frame buffer.
	typedef struct packed {
		logic       we;
		logic [6:0] addr;
		logic [7:0] data;
	} fb_write_t;

endpackage

// ==== verification/demod_model.sv ====
// Demodulator stand-in that plays frames into the receive block.
`timescale 1ns/1ps
module demod_model
	import radio_rx_pkg::*;
(
	input  wire logic clock,
	output demod_in_t demod
);
	initial demod = '0;
	// Data flips in idle cycles, so a stale octet never looks fresh.
	task automatic frame(input logic [4:0] lv, input int n, gap,
		input logic [7:0] b, c, input logic f, m);
		@(posedge clock);
		demod.signal_level <= lv;
		demod.sync_found <= 1'b1;
		for (int i = 0; i < n; i++) begin
			@(posedge clock);
			demod.sync_found <= 1'b0;
			{demod.symbol_valid, demod.octet_valid} <= 2'b11;
			{demod.correlation, demod.octet} <= {c, b + 8'(i)};
			repeat (gap) begin
				@(posedge clock);
				{demod.symbol_valid, demod.octet_valid} <= 2'b00;
				demod.octet <= ~demod.octet;
			end
		end
		@(posedge clock);
		{demod.sync_found, demod.symbol_valid, demod.octet_valid} <= 3'h0;
		{demod.frame_end, demod.fcs_ok, demod.addr_match} <= {1'b1, f, m};
		{demod.pending, demod.ed_level} <= {m, b};
		@(posedge clock);
		demod.frame_end <= 1'b0;
		{demod.fcs_ok, demod.addr_match, demod.pending} <= ~{f, m, m};
		demod.ed_level <= ~b;
	endtask
endmodule // demod_model

// ==== verification/radio_receive_control_asserts.sv ====
// Port-level assertions for the receive control block.
`timescale 1ns/1ps
module radio_receive_control_asserts
	import radio_rx_pkg::*;
#(
	parameter int FB_ADDR_WIDTH = 7,
	parameter int LQI_SHIFT     = 3
) (
	input wire logic       clock,
	input wire logic       rst,
	input wire logic       clk_en,
	input wire logic [5:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic       reg_wr,
	input wire logic       reg_rd,
	input wire logic [7:0] reg_rdata,
	input wire logic       irq,
	input wire demod_in_t  demod,
	input wire logic       sel_n,
	input wire logic       frame_read_mode,
	input wire fb_write_t  fb_write,
	input wire state_control_register_t state_control_register
);
	logic [7:0] sync_reg;
	logic [7:0] mask_reg;
	wire        wr_ok    = reg_wr && clk_en;
	wire        go_cmd   = wr_ok && reg_addr == STATE_CONTROL_ADDR;
	wire  [4:0] cmd      = reg_wdata[4:0];
	wire        listen   = state_control_register == ST_RX_LISTEN;
	wire        sync_now = demod.sync_found && clk_en;
	wire        blocked  = sync_reg[SYNC_DISABLE_BIT]
		|| demod.signal_level < {1'b0, sync_reg[3:0]};
	// Shadows of host writes; the ports alone cannot show threshold or mask.
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			sync_reg <= SYNC_CONTROL_RESET;
			mask_reg <= IRQ_MASK_RESET;
		end else if (wr_ok && reg_addr == SYNC_CONTROL_ADDR) begin
			sync_reg <= reg_wdata & SYNC_CONTROL_RW_MASK;
		end else if (wr_ok && reg_addr == IRQ_MASK_ADDR) begin
			mask_reg <= reg_wdata;
		end
	end
	////////////////////////////////////////////////////////////////////////
	default clocking @(posedge clock); endclocking
	default disable iff (rst);
	sequence sync_seen;
		sync_now && listen && !reg_wr;
	endsequence
	sequence rx_begun;
		state_control_register == ST_RX_BUSY && $past(state_control_register) == ST_RX_LISTEN;
	endsequence
	sequence rx_ends;
		clk_en && demod.frame_end && state_control_register == ST_RX_BUSY;
	endsequence
	rx_cmd_a: assert property (go_cmd && cmd == CMD_RX
		&& state_control_register inside {ST_IDLE, ST_LOCKED} |=> listen)
		else $error("receive command not taken");
	aack_cmd_a: assert property (go_cmd && cmd == CMD_AACK_RX
		&& state_control_register inside {ST_IDLE, ST_LOCKED, ST_ARET_TX}
		|=> state_control_register == ST_AACK_LISTEN) else $error("auto-ack not taken");
	weak_sync_a: assert property (sync_seen ##0 blocked |=> listen)
		else $error("blocked sync began a frame");
	rx_start_a: assert property (rx_begun |-> $past(sync_now))
		else $error("frame began without sync");
	start_irq_a: assert property (rx_begun
		##0 mask_reg[IRQ_FRAME_START_BIT] |-> irq) else $error("no start irq");
	rx_end_a: assert property (rx_ends |=> listen && fb_write.we)
		else $error("frame end not handled");
	done_irq_a: assert property (rx_ends
		##0 mask_reg[IRQ_FRAME_DONE_BIT] |=> irq) else $error("no done irq");
	sync_read_a: assert property (reg_rd && clk_en
		&& reg_addr == SYNC_CONTROL_ADDR |=> reg_rdata == sync_reg)
		else $error("sync control read wrong");
endmodule // radio_receive_control_asserts

bind radio_receive_control radio_receive_control_asserts #(
	.FB_ADDR_WIDTH(FB_ADDR_WIDTH), .LQI_SHIFT(LQI_SHIFT)) chk_i (.*);

// ==== verification/radio_receive_control_bench.sv ====
// Self-checking bench for the receive control block.
`timescale 1ns/1ps
module radio_receive_control_bench
	import radio_rx_pkg::*;
();
	logic        clock, rst, clk_en, reg_wr, reg_rd, sel_n, frame_read_mode;
	logic        irq, rd_seen;
	logic [5:0]  reg_addr;
	logic [7:0]  reg_wdata, reg_rdata, lb, lq;
	demod_in_t   demod;
	fb_write_t   fb_write;
	state_control_register_t  state_control_register;
	logic [15:0] rd_q[$], fb_q[$], e;
	int          n_fail, samples_checked;
	integer      seed = 32'h5509A285;
	logic [4:0]  cmds[8] = '{CMD_RX, CMD_IDLE, CMD_AACK_RX, CMD_IDLE,
		CMD_ARET_TX, CMD_AACK_RX, CMD_LOCK, CMD_RX};
	state_control_register_t  sts[8] = '{ST_RX_LISTEN, ST_IDLE, ST_AACK_LISTEN, ST_IDLE,
		ST_ARET_TX, ST_AACK_LISTEN, ST_LOCKED, ST_RX_LISTEN};
	radio_receive_control #(.FB_ADDR_WIDTH(7), .LQI_SHIFT(3)) DUT (
		.clock(clock), .rst(rst), .clk_en(clk_en), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
		.reg_rdata(reg_rdata), .irq(irq), .demod(demod), .sel_n(sel_n),
		.frame_read_mode(frame_read_mode), .fb_write(fb_write),
		.state_control_register(state_control_register));
	demod_model dm (.clock(clock), .demod(demod));
	initial clock = 1'b0;
	always #50 clock = ~clock;
	////////////////////////////////////////////////////////////////////////
	task automatic chk(input string s, input logic [15:0] v, x);
		samples_checked++;
		if (v !== x) begin
			n_fail++;
			$display("mismatch %s expected %h seen %h", s, x, v);
		end
	endtask
	task automatic wr(input logic [5:0] a, input logic [7:0] d);
		@(posedge clock);
		{reg_addr, reg_wdata, reg_wr} <= {a, d, 1'b1};
		@(posedge clock);
		reg_wr <= 1'b0;
	endtask
	task automatic rd(input logic [5:0] a, input logic [7:0] x, m);
		@(posedge clock);
		{reg_addr, reg_rd} <= {a, 1'b1};
		rd_q.push_back({m, x});
		@(posedge clock);
		reg_rd <= 1'b0;
	endtask
	task automatic late(input int k, input logic [5:0] a, input logic [7:0] d);
		repeat (k) @(posedge clock);
		wr(a, d);
	endtask
	task automatic st(input state_control_register_t x);
		#1 chk("state", 16'(state_control_register), 16'(x));
	endtask
	task automatic fr(input logic [4:0] lv, input int n, gap,
		input logic f, m, acc);
		logic [7:0]  b, c;
		logic [11:0] s;
		b = 8'($random(seed));
		c = (n == 10) ? 8'hFF : 8'($random(seed));
		s = 12'((n * int'(c)) >> 3);
		lb = b;
		lq = (n < 2) ? 8'h00 : (s > 12'hFF) ? 8'hFF : s[7:0];
		for (int i = 0; i < n && acc; i++)
			fb_q.push_back({1'b1, 7'(i), b + 8'(i)});
		if (acc && m)
			fb_q.push_back({1'b1, 7'(n), lq});
		dm.frame(lv, n, gap, b, c, f, m);
		repeat (3) @(posedge clock);
	endtask
	task automatic end_sim;
		$display("checks %0d mismatches %0d", samples_checked, n_fail);
		if (n_fail == 0 && samples_checked > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask
	// Results are matched oldest first, so a dropped or extra write shows.
	always @(posedge clock) begin
		rd_seen <= reg_rd && clk_en;
		if (rd_seen) begin
			e = rd_q.size() ? rd_q.pop_front() : 16'hFFFF;
			chk("read", 16'(reg_rdata & e[15:8]), 16'(e[7:0]));
		end
		if (fb_write.we)
			chk("buffer", fb_write, fb_q.size() ? fb_q.pop_front() : 16'h0);
	end
	initial begin
		#2000000;
		n_fail++;
		end_sim();
	end
	////////////////////////////////////////////////////////////////////////
	initial begin
		{rst, clk_en, sel_n, reg_wr, reg_rd, frame_read_mode} = 6'h38;
		{reg_addr, reg_wdata, n_fail, samples_checked} = '0;
		repeat (8) @(posedge clock);
		rst <= 1'b0;
		rd(SYNC_CONTROL_ADDR, 8'h00, 8'hFF);
		rd(6'h3F, 8'h00, 8'hFF);
		wr(SYNC_CONTROL_ADDR, 8'hFF);
		rd(SYNC_CONTROL_ADDR, 8'h8F, 8'hFF);
		wr(SYNC_CONTROL_ADDR, 8'h03);
		wr(IRQ_MASK_ADDR, 8'h0C);
		for (int i = 0; i < 8; i++) begin
			wr(STATE_CONTROL_ADDR, {3'h0, cmds[i]});
			st(sts[i]);
		end
		@(posedge clock);
		clk_en <= 1'b0;
		wr(STATE_CONTROL_ADDR, {3'h0, CMD_IDLE});
		st(ST_RX_LISTEN);
		@(posedge clock);
		clk_en <= 1'b1;
		$display("end of registers and commands");
		fr(5'd2, 3, 0, 1, 1, 0);
		fr(5'd3, 4, 1, 1, 1, 1);
		#1 chk("irq", 16'(irq), 16'h0001);
		rd(IRQ_STATUS_ADDR, 8'h0C, 8'hFF);
		rd(ENERGY_LEVEL_ADDR, lb, 8'hFF);
		rd(SIGNAL_STRENGTH_ADDR, 8'h80, 8'h80);
		rd(LQI_ADDR, lq, 8'hFF);
		#1 chk("irq", 16'(irq), 16'h0000);
		fork
			fr(5'd9, 10, 2, 0, 1, 1);
			late(5, STATE_CONTROL_ADDR, {3'h0, CMD_IDLE});
		join
		st(ST_RX_LISTEN);
		fr(5'd3, 1, 0, 1, 1, 1);
		$display("end of frames");
		wr(SYNC_CONTROL_ADDR, 8'h80);
		fr(5'd20, 2, 0, 1, 1, 0);
		st(ST_RX_LISTEN);
		wr(SYNC_CONTROL_ADDR, 8'h00);
		fork
			fr(5'd0, 5, 2, 1, 1, 1);
			late(4, SYNC_CONTROL_ADDR, 8'h80);
		join
		wr(SYNC_CONTROL_ADDR, 8'h00);
		$display("end of sync control");
		wr(CONTROL_TWO_ADDR, 8'h80);
		fr(5'd4, 2, 0, 0, 1, 1);
		fr(5'd4, 2, 0, 1, 1, 1);
		fr(5'd4, 2, 0, 1, 1, 0);
		wr(STATE_CONTROL_ADDR, {3'h0, CMD_IDLE});
		st(ST_RX_LISTEN);
		@(posedge clock);
		{sel_n, frame_read_mode} <= 2'b01;
		@(posedge clock);
		sel_n <= 1'b1;
		@(posedge clock);
		frame_read_mode <= 1'b0;
		fr(5'd4, 2, 0, 0, 1, 1);
		wr(CONTROL_TWO_ADDR, 8'h00);
		$display("end of protection");
		wr(STATE_CONTROL_ADDR, {3'h0, CMD_IDLE});
		wr(STATE_CONTROL_ADDR, {3'h0, CMD_AACK_RX});
		rd(IRQ_STATUS_ADDR, 8'h0C, 8'hFF);
		fr(5'd4, 3, 0, 1, 1, 1);
		rd(IRQ_STATUS_ADDR, 8'h0C, 8'hFF);
		rd(SIGNAL_STRENGTH_ADDR, 8'hC0, 8'hC0);
		fr(5'd4, 3, 0, 1, 0, 1);
		rd(IRQ_STATUS_ADDR, 8'h04, 8'hFF);
		st(ST_AACK_LISTEN);
		$display("end of extended mode");
		repeat (4) @(posedge clock);
		chk("left", 16'(fb_q.size() + rd_q.size()), 16'h0000);
		end_sim();
	end
endmodule // radio_receive_control_bench
